/* File: ulmc_pkg.sv */
// constants, field positions and carriers for the line and modem control block
package ulmc_pkg;

    // ************************************************************
    // register addresses
    // ************************************************************
    localparam logic [2:0] ADDR_DATA = 3'h0;
    localparam logic [2:0] ADDR_IER_DIVH = 3'h1;
    localparam logic [2:0] ADDR_FEAT = 3'h2;
    localparam logic [2:0] ADDR_LINE_FMT = 3'h3;
    localparam logic [2:0] ADDR_MODEM_OUT = 3'h4;
    localparam logic [2:0] ADDR_LINE_COND = 3'h5;
    localparam logic [2:0] ADDR_MODEM_IN = 3'h6;
    localparam logic [2:0] ADDR_DIV_FRAC = 3'h7;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int LF_PAR_EN = 3;
    localparam int LF_EVEN = 4;
    localparam int LF_FORCE = 5;
    localparam int LF_BREAK = 6;
    localparam int LF_DIV = 7;
    localparam int LF_STOP = 2;
    localparam int MO_DTR = 0;
    localparam int MO_RTS = 1;
    localparam int MO_OP1 = 2;
    localparam int MO_OP2 = 3;
    localparam int MO_LOOP = 4;
    localparam int MO_XANY = 5;
    localparam int MO_IR = 6;
    localparam int MO_PRESC = 7;
    localparam int FE_FIFO = 0;
    localparam int FE_ENH = 4;
    localparam int FE_ARTS = 6;
    localparam int FE_ACTS = 7;
    localparam int IE_MODEM = 3;

    // ************************************************************
    // reset values, sizes and counts
    // ************************************************************
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [3:0] FRAC_RST = 4'h0;
    localparam int FIFO_DEPTH = 64;
    localparam logic [6:0] FIFO_FULL_ON = 7'h40;
    localparam logic [6:0] FIFO_FULL_OFF = 7'h01;
    localparam logic [6:0] RTS_STOP_LEVEL = 7'h3C;
    localparam int PRESC_DIV = 4;
    localparam logic [1:0] PRESC_LAST = 2'(PRESC_DIV - 1);

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic done;
        logic [7:0] data;
        logic par_bit;
        logic stop_ok;
        logic brk;
    } ulmc_rx_ev_s;

    typedef struct packed {
        logic cd_n;
        logic ri_n;
        logic dsr_n;
        logic cts_n;
    } ulmc_modem_in_s;

    typedef struct packed {
        logic [1:0] word_len;
        logic stop2;
        logic par_en;
    } ulmc_frame_fmt_s;

    typedef struct packed {
        logic brk;
        logic fe;
        logic pe;
        logic [7:0] data;
    } ulmc_rx_entry_s;

endpackage

/* File: ulmc_top.sv */
// line format, modem control and line/modem status logic of one serial channel
`timescale 1ns/1ps
// Overview of operation
// RULE1 - forced parity sends and checks constant bit: 1 when even clear, 0 when set
// RULE2 - break field holds serial output low until software clears it; code drives serial output high instead while loopback or infrared is on
// RULE3 - divisor access field maps shared addresses to divisor registers
// RULE4 - terminal-ready pin is low when field is 1, high after reset
// RULE5 - request-to-send pin low when field is 1; shared with auto flow and half-duplex
// RULE6 - spare output one feeds the ring input during loopback
// RULE7 - output two at 0: interrupt outputs off, pin high; at 1: driven, pin low
// RULE8 - loopback field selects internal loopback, clear restores external operation
// RULE9 - xon-any: any received character resumes transmit; flow characters not stored
// RULE10 - infrared field routes transmit and receive through infrared path, idling low
// RULE11 - prescaler field divides input clock by four before baud generator
// RULE12 - xon-any, infrared and prescaler act only with enhanced enable set
// RULE13 - data ready reads 1 while any received character is held
// RULE14 - character arriving with receive store full sets overrun and is dropped
// RULE15 - parity and framing error describe the character at the read head
// RULE16 - line low for a frame sets break; only one break character stored
// RULE17 - holding empty sets on transfer to shifter, clears on host load
// RULE18 - transmitter empty only when holding and shift register both empty
// RULE19 - receive error flag set while any stored character carries an error
// RULE20 - modem deltas set on change, ring only on rising pin; request interrupt
// RULE21 - auto clear-to-send: high pin halts after current character, low resumes
// RULE22 - clear-to-send status is inverted pin, or request-to-send field in loopback
// RULE23 - data-set-ready status is inverted pin, or terminal-ready field in loopback
// RULE24 - ring and carrier status inverted pins, or modem bits 2 and 3 in loopback
// RULE25 - even-select picks odd at 0 and even at 1 for send and check
// RULE26 - reading modem status clears deltas; reading line status clears overrun
// RULE27 - all control fields and error and delta flags reset to 0
module ulmc_top (
    input wire logic CLOCK,
    input wire logic SRST,
    input wire logic [2:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    input wire ulmc_pkg::ulmc_rx_ev_s RX_EV,
    input wire logic XONOFF_HIT,
    input wire logic SW_FLOW_ON,
    input wire logic TX_BIT_IN,
    input wire logic TX_TAKE,
    input wire logic TX_SHIFT_BUSY,
    input wire logic SER_RX_IN,
    input wire logic IR_RX_IN,
    input wire logic RS485_EN,
    input wire logic RS485_TX_ACTIVE,
    input wire ulmc_pkg::ulmc_modem_in_s MODEM_IN,
    output logic SER_TX_OUT,
    output logic IR_TX_OUT,
    output logic IR_SEL,
    output logic RX_LINE_OUT,
    output logic [7:0] TX_DATA,
    output logic TX_VALID,
    output logic TX_PARITY,
    output ulmc_pkg::ulmc_frame_fmt_s FRAME_FMT,
    output logic TX_HALT,
    output logic TX_RESUME,
    output logic BAUD_TICK,
    output logic [15:0] DIVISOR,
    output logic [3:0] DIV_FRAC,
    output logic DTR_N,
    output logic RTS_N,
    output logic OP2_N,
    output logic INT_OE_N,
    output logic MS_INT_REQ
);

    // ************************************************************
    // parity helper
    // ************************************************************
    function automatic logic parity_of(input logic [7:0] data, input logic [1:0] wl,
                                       input logic even, input logic force_par);
        logic [7:0] mask;
        logic ones;
        mask = 8'hFF >> (2'h3 - wl);
        ones = ^(data & mask);
        if (force_par) begin
            parity_of = ~even;
        end else begin
            parity_of = even ? ones : ~ones;
        end
    endfunction

    // ************************************************************
    // registers and decode
    // ************************************************************
    logic [7:0] line_format_control_q;
    logic [7:0] modem_output_control_q;
    logic [7:0] feat_q;
    logic [7:0] ier_q;
    logic [7:0] div_low_q;
    logic [7:0] divisor_high_q;
    logic [3:0] divisor_fraction_q;
    logic [7:0] thr_q;
    logic hold_v_q;
    logic dlab;
    logic enh;
    logic loop_en;
    logic xany_en;
    logic ir_en;
    logic presc_en;
    logic rd_lc;
    logic rd_mi;
    logic rd_rhr;
    logic wr_thr;

    assign dlab = line_format_control_q[ulmc_pkg::LF_DIV];
    assign enh = feat_q[ulmc_pkg::FE_ENH];
    assign loop_en = modem_output_control_q[ulmc_pkg::MO_LOOP];
    assign xany_en = modem_output_control_q[ulmc_pkg::MO_XANY] & enh; // RULE12
    assign ir_en = modem_output_control_q[ulmc_pkg::MO_IR] & enh; // RULE12
    assign presc_en = modem_output_control_q[ulmc_pkg::MO_PRESC] & enh; // RULE12
    assign rd_lc = RD && ADDR == ulmc_pkg::ADDR_LINE_COND;
    assign rd_mi = RD && ADDR == ulmc_pkg::ADDR_MODEM_IN;
    assign rd_rhr = RD && ADDR == ulmc_pkg::ADDR_DATA && !dlab; // RULE3
    assign wr_thr = WR && ADDR == ulmc_pkg::ADDR_DATA && !dlab; // RULE3

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            line_format_control_q <= ulmc_pkg::REG_RST; // RULE27
            modem_output_control_q <= ulmc_pkg::REG_RST; // RULE27
            feat_q <= ulmc_pkg::REG_RST;
            ier_q <= ulmc_pkg::REG_RST;
        end else if (WR) begin
            case (ADDR)
                ulmc_pkg::ADDR_LINE_FMT: begin
                    line_format_control_q <= WDATA;
                end
                ulmc_pkg::ADDR_MODEM_OUT: begin
                    // enhanced fields only take a write with the enhanced enable set
                    modem_output_control_q <= {enh ? WDATA[7:5] : modem_output_control_q[7:5],
                                               WDATA[4:0]}; // RULE12
                end
                ulmc_pkg::ADDR_FEAT: begin
                    feat_q <= WDATA;
                end
                ulmc_pkg::ADDR_IER_DIVH: begin
                    if (!dlab) begin
                        ier_q <= WDATA; // RULE3
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            div_low_q <= ulmc_pkg::REG_RST;
            divisor_high_q <= ulmc_pkg::REG_RST;
            divisor_fraction_q <= ulmc_pkg::FRAC_RST;
        end else if (WR && dlab) begin
            if (ADDR == ulmc_pkg::ADDR_DATA) begin
                div_low_q <= WDATA; // RULE3
            end
            if (ADDR == ulmc_pkg::ADDR_IER_DIVH) begin
                divisor_high_q <= WDATA; // RULE3
            end
            if (ADDR == ulmc_pkg::ADDR_DIV_FRAC && enh) begin
                divisor_fraction_q <= WDATA[3:0];
            end
        end
    end

    // ************************************************************
    // transmit holding register
    // ************************************************************
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            thr_q <= ulmc_pkg::REG_RST;
            hold_v_q <= 1'b0;
        end else begin
            if (wr_thr) begin
                thr_q <= WDATA;
            end
            if (wr_thr) begin
                hold_v_q <= 1'b1; // RULE17
            end else if (TX_TAKE) begin
                hold_v_q <= 1'b0; // RULE17
            end
        end
    end

    // ************************************************************
    // receive store with error tags
    // ************************************************************
    ulmc_pkg::ulmc_rx_entry_s mem [ulmc_pkg::FIFO_DEPTH];
    ulmc_pkg::ulmc_rx_entry_s head;
    ulmc_pkg::ulmc_rx_entry_s new_ent;
    logic [5:0] wp_q;
    logic [5:0] rp_q;
    logic [6:0] cnt_q;
    logic [6:0] err_cnt_q;
    logic full;
    logic storable;
    logic push;
    logic pop;
    logic fifo_flush;
    logic overrun_q;
    logic brk_hold_q;
    logic rx_line_q;

    assign head = mem[rp_q];
    assign full = cnt_q == (feat_q[ulmc_pkg::FE_FIFO] ? ulmc_pkg::FIFO_FULL_ON
                                                      : ulmc_pkg::FIFO_FULL_OFF);
    assign storable = RX_EV.done && !(XONOFF_HIT && SW_FLOW_ON) // RULE9
                      && !(RX_EV.brk && brk_hold_q); // RULE16
    assign push = storable && !full; // RULE14
    assign pop = rd_rhr && cnt_q != 7'h00;
    assign fifo_flush = WR && ADDR == ulmc_pkg::ADDR_FEAT
                        && WDATA[ulmc_pkg::FE_FIFO] != feat_q[ulmc_pkg::FE_FIFO];
    assign new_ent.brk = RX_EV.brk; // RULE16
    assign new_ent.fe = ~RX_EV.stop_ok; // RULE15
    assign new_ent.pe = line_format_control_q[ulmc_pkg::LF_PAR_EN]
                        && RX_EV.par_bit != parity_of(RX_EV.data, line_format_control_q[1:0],
                                                      line_format_control_q[ulmc_pkg::LF_EVEN],
                                                      line_format_control_q[ulmc_pkg::LF_FORCE]);
    assign new_ent.data = RX_EV.data;

    always_ff @(posedge CLOCK) begin
        if (push) begin
            mem[wp_q] <= new_ent;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SRST || fifo_flush) begin
            wp_q <= 6'h00;
            rp_q <= 6'h00;
            cnt_q <= 7'h00;
            err_cnt_q <= 7'h00;
        end else begin
            if (push) begin
                wp_q <= wp_q + 6'h01;
            end
            if (pop) begin
                rp_q <= rp_q + 6'h01;
            end
            cnt_q <= cnt_q + 7'(push) - 7'(pop); // RULE13
            err_cnt_q <= err_cnt_q + 7'(push && (new_ent.brk | new_ent.fe | new_ent.pe))
                         - 7'(pop && (head.brk | head.fe | head.pe)); // RULE19
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            overrun_q <= 1'b0; // RULE27
        end else if (storable && full) begin
            overrun_q <= 1'b1; // RULE14
        end else if (rd_lc) begin
            overrun_q <= 1'b0; // RULE26
        end
    end

    // one break character per break; rearmed once the line goes back high
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            brk_hold_q <= 1'b0;
        end else if (push && RX_EV.brk) begin
            brk_hold_q <= 1'b1; // RULE16
        end else if (rx_line_q) begin
            brk_hold_q <= 1'b0;
        end
    end

    // ************************************************************
    // serial routing, loopback and infrared
    // ************************************************************
    logic tx_eff;

    assign tx_eff = line_format_control_q[ulmc_pkg::LF_BREAK] ? 1'b0 : TX_BIT_IN; // RULE2

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            SER_TX_OUT <= 1'b1;
            IR_TX_OUT <= 1'b0;
            IR_SEL <= 1'b0;
            rx_line_q <= 1'b1;
        end else begin
            SER_TX_OUT <= loop_en | ir_en | tx_eff; // RULE2 RULE8 RULE10
            IR_TX_OUT <= ir_en & ~loop_en & ~tx_eff; // RULE10
            IR_SEL <= ir_en; // RULE10
            rx_line_q <= loop_en ? tx_eff : (ir_en ? IR_RX_IN : SER_RX_IN); // RULE8 RULE10
        end
    end
    assign RX_LINE_OUT = rx_line_q;

    // ************************************************************
    // modem inputs, deltas and status
    // ************************************************************
    logic [3:0] ms_lvl;
    logic [3:0] ms_prev_q;
    logic [3:0] delta_q;
    logic [3:0] delta_new;
    logic primed_q;

    // order: 3 carrier, 2 ring, 1 data-set-ready, 0 clear-to-send
    assign ms_lvl = loop_en ? {modem_output_control_q[ulmc_pkg::MO_OP2],
                               modem_output_control_q[ulmc_pkg::MO_OP1],
                               modem_output_control_q[ulmc_pkg::MO_DTR],
                               modem_output_control_q[ulmc_pkg::MO_RTS]} // RULE6 RULE22 RULE23 RULE24
                            : ~{MODEM_IN.cd_n, MODEM_IN.ri_n, MODEM_IN.dsr_n, MODEM_IN.cts_n};
    assign delta_new = primed_q ? {ms_lvl[3] ^ ms_prev_q[3], ms_prev_q[2] & ~ms_lvl[2],
                                   ms_lvl[1:0] ^ ms_prev_q[1:0]} : 4'h0; // RULE20

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            ms_prev_q <= 4'h0;
            primed_q <= 1'b0;
            delta_q <= 4'h0; // RULE27
            MS_INT_REQ <= 1'b0;
        end else begin
            ms_prev_q <= ms_lvl;
            primed_q <= 1'b1;
            delta_q <= (delta_q & {4{~rd_mi}}) | delta_new; // RULE26
            MS_INT_REQ <= ier_q[ulmc_pkg::IE_MODEM] & (|delta_q); // RULE20
        end
    end

    // ************************************************************
    // modem outputs, flow control and clocking
    // ************************************************************
    logic [1:0] presc_cnt_q;

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            DTR_N <= 1'b1;
            RTS_N <= 1'b1;
            OP2_N <= 1'b1;
            INT_OE_N <= 1'b1;
            TX_HALT <= 1'b0;
            TX_RESUME <= 1'b0;
        end else begin
            DTR_N <= ~modem_output_control_q[ulmc_pkg::MO_DTR]; // RULE4
            if (RS485_EN) begin
                RTS_N <= ~RS485_TX_ACTIVE; // RULE5
            end else if (feat_q[ulmc_pkg::FE_ARTS]) begin
                RTS_N <= cnt_q >= ulmc_pkg::RTS_STOP_LEVEL; // RULE5
            end else begin
                RTS_N <= ~modem_output_control_q[ulmc_pkg::MO_RTS]; // RULE5
            end
            OP2_N <= ~modem_output_control_q[ulmc_pkg::MO_OP2]; // RULE7
            INT_OE_N <= ~modem_output_control_q[ulmc_pkg::MO_OP2]; // RULE7
            TX_HALT <= feat_q[ulmc_pkg::FE_ACTS] & ~ms_lvl[0]; // RULE21
            TX_RESUME <= xany_en & RX_EV.done; // RULE9
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            presc_cnt_q <= 2'h0;
            BAUD_TICK <= 1'b0;
        end else begin
            presc_cnt_q <= presc_en ? presc_cnt_q + 2'h1 : 2'h0;
            BAUD_TICK <= !presc_en || presc_cnt_q == ulmc_pkg::PRESC_LAST; // RULE11
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            TX_PARITY <= 1'b0;
            FRAME_FMT <= '0;
        end else begin
            TX_PARITY <= parity_of(thr_q, line_format_control_q[1:0],
                                   line_format_control_q[ulmc_pkg::LF_EVEN],
                                   line_format_control_q[ulmc_pkg::LF_FORCE]); // RULE1 RULE25
            FRAME_FMT.word_len <= line_format_control_q[1:0];
            FRAME_FMT.stop2 <= line_format_control_q[ulmc_pkg::LF_STOP];
            FRAME_FMT.par_en <= line_format_control_q[ulmc_pkg::LF_PAR_EN];
        end
    end
    assign TX_DATA = thr_q;
    assign TX_VALID = hold_v_q;
    assign DIVISOR = {divisor_high_q, div_low_q};
    assign DIV_FRAC = divisor_fraction_q;

    // ************************************************************
    // read data
    // ************************************************************
    logic [7:0] lc_val;
    logic [7:0] rd_mux;

    assign lc_val = {err_cnt_q != 7'h00, // RULE19
                     !hold_v_q && !TX_SHIFT_BUSY, // RULE18
                     !hold_v_q, // RULE17
                     cnt_q != 7'h00 ? {head.brk, head.fe, head.pe} : 3'h0, // RULE15
                     overrun_q, cnt_q != 7'h00}; // RULE13

    always_comb begin
        rd_mux = 8'h00;
        case (ADDR)
            ulmc_pkg::ADDR_DATA: rd_mux = dlab ? div_low_q : head.data; // RULE3
            ulmc_pkg::ADDR_IER_DIVH: rd_mux = dlab ? divisor_high_q : ier_q; // RULE3
            ulmc_pkg::ADDR_FEAT: rd_mux = feat_q;
            ulmc_pkg::ADDR_LINE_FMT: rd_mux = line_format_control_q;
            ulmc_pkg::ADDR_MODEM_OUT: rd_mux = modem_output_control_q;
            ulmc_pkg::ADDR_LINE_COND: rd_mux = lc_val;
            ulmc_pkg::ADDR_MODEM_IN: rd_mux = {ms_lvl, delta_q};
            ulmc_pkg::ADDR_DIV_FRAC: rd_mux = (dlab && enh) ? {4'h0, divisor_fraction_q} : 8'h00;
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            RDATA <= 8'h00;
        end else begin
            RDATA <= RD ? rd_mux : 8'h00;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SRST);

    sequence presc_tick_s;
        presc_en && BAUD_TICK;
    endsequence
    sequence presc_gap_s;
        !BAUD_TICK ##1 BAUD_TICK;
    endsequence

    force_parity_a: assert property ( // RULE1
        line_format_control_q[ulmc_pkg::LF_PAR_EN] && line_format_control_q[ulmc_pkg::LF_FORCE]
        |=> TX_PARITY == !$past(line_format_control_q[ulmc_pkg::LF_EVEN]))
        else $error("forced parity bit wrong");
    break_low_a: assert property ( // RULE2
        line_format_control_q[ulmc_pkg::LF_BREAK] && !loop_en && !ir_en |=> !SER_TX_OUT)
        else $error("break not holding line low");
    divisor_map_a: assert property ( // RULE3
        RD && ADDR == ulmc_pkg::ADDR_DATA && dlab |=> RDATA == $past(div_low_q))
        else $error("divisor low not mapped");
    op2_int_a: assert property ( // RULE7
        ##1 OP2_N == !$past(modem_output_control_q[ulmc_pkg::MO_OP2]) && INT_OE_N == OP2_N)
        else $error("output two or interrupt enable wrong");
    loop_rx_a: assert property ( // RULE8
        loop_en |=> RX_LINE_OUT == $past(tx_eff))
        else $error("loopback receive path wrong");
    overrun_set_a: assert property ( // RULE14
        storable && full && !fifo_flush |=> overrun_q && cnt_q == $past(cnt_q) - 7'($past(pop)))
        else $error("overrun not flagged or character stored");
    ready_flag_a: assert property ( // RULE13
        rd_lc |=> RDATA[0] == ($past(cnt_q) != 7'h00))
        else $error("data ready flag wrong");
    delta_clear_a: assert property ( // RULE26
        rd_mi && delta_new == 4'h0 |=> delta_q == 4'h0 ##1 !MS_INT_REQ)
        else $error("modem deltas not cleared by read");
    presc_tick_a: assert property ( // RULE11
        presc_tick_s ##1 presc_en [*3]
        |-> !$past(BAUD_TICK, 2) && !$past(BAUD_TICK) ##0 presc_gap_s)
        else $error("prescaler tick spacing wrong");
    enh_gate_a: assert property ( // RULE12
        !enh |=> !IR_SEL && !TX_RESUME)
        else $error("enhanced field acted without enable");

endmodule

/* File: ulmc_peer.sv */
// far-side model: modem pins and received character events
`timescale 1ns/1ps
module ulmc_peer (
    input wire logic clock,
    output ulmc_pkg::ulmc_modem_in_s modem,
    output ulmc_pkg::ulmc_rx_ev_s rx_ev
);
    initial begin
        modem = 4'hF;
        rx_ev = '0;
    end
    task automatic pins(input logic [3:0] v);
        @(posedge clock);
        modem <= v;
        repeat (3) @(posedge clock);
    endtask
    // data shows garbage once the event pulse is over
    task automatic send(input logic [7:0] d, input logic ok);
        @(posedge clock);
        rx_ev <= {1'b1, d, 1'b0, ok, 1'b0};
        @(posedge clock);
        rx_ev <= {1'b0, ~d, 3'h0};
        repeat (2) @(posedge clock);
    endtask
endmodule

/* File: ulmc_top_tb_top.sv */
// self-checking bench for the line and modem control block
`timescale 1ns/1ps
module ulmc_top_tb_top;
    logic clock = 0, srst = 1, wen = 0, ren = 0, rd_q = 0, take = 0, busy = 0, tx_bit = 1;
    logic [2:0] addr = '0;
    logic [7:0] wdata = '0, rdata, d;
    logic [15:0] exp_q[$], e, divisor;
    int failures = 0, n_checks = 0, seed = 1, ticks, res_n = 0;
    logic xhit = 0, rs_en = 0, tx_valid, tx_halt, tx_res;
    ulmc_pkg::ulmc_modem_in_s modem;
    ulmc_pkg::ulmc_rx_ev_s rx_ev;
    logic ser_tx, ir_tx, ir_sel, baud, dtr_n, rts_n, op2_n, oe_n, ms_int, tx_par;
    ulmc_top u_dut (.CLOCK(clock), .SRST(srst), .ADDR(addr), .WDATA(wdata), .WR(wen),
        .RD(ren), .RDATA(rdata), .RX_EV(rx_ev), .XONOFF_HIT(xhit), .SW_FLOW_ON(xhit),
        .TX_BIT_IN(tx_bit), .TX_TAKE(take), .TX_SHIFT_BUSY(busy), .SER_RX_IN(ser_tx),
        .IR_RX_IN(1'b0), .RS485_EN(rs_en), .RS485_TX_ACTIVE(busy), .MODEM_IN(modem),
        .SER_TX_OUT(ser_tx), .IR_TX_OUT(ir_tx), .IR_SEL(ir_sel), .RX_LINE_OUT(),
        .TX_DATA(), .TX_VALID(tx_valid), .TX_PARITY(tx_par), .FRAME_FMT(), .TX_HALT(tx_halt),
        .TX_RESUME(tx_res), .BAUD_TICK(baud), .DIVISOR(divisor), .DIV_FRAC(), .DTR_N(dtr_n),
        .RTS_N(rts_n), .OP2_N(op2_n), .INT_OE_N(oe_n), .MS_INT_REQ(ms_int));
    ulmc_peer peer (.clock(clock), .modem(modem), .rx_ev(rx_ev));
    initial forever #12.5 clock = ~clock;
    task automatic chk(input string n, input logic [15:0] x, input logic [15:0] g);
        n_checks++;
        if (g !== x) begin
            failures++;
            $display("BAD %s exp %h got %h", n, x, g);
        end
    endtask
    task automatic final_report;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clock);
        addr <= a;
        wdata <= v;
        wen <= 1;
        @(posedge clock);
        wen <= 0;
        @(posedge clock);
        @(negedge clock);
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] x, input logic [7:0] m);
        @(posedge clock);
        exp_q.push_back({m, x & m});
        addr <= a;
        ren <= 1;
        @(posedge clock);
        ren <= 0;
        @(negedge clock);
    endtask
    // read data stand only in the cycle after the strobe
    always @(posedge clock) begin
        if (rd_q) begin
            e = exp_q.pop_front();
            chk("rdata", e[7:0], rdata & e[15:8]);
        end
        if (tx_res === 1'b1) res_n++;
        rd_q <= ren;
    end
    initial begin
        repeat (5000) @(posedge clock);
        failures++;
        final_report;
    end
    initial begin
        repeat (4) @(posedge clock);
        srst <= 0;
        rd(3, 8'h00, 8'hFF);
        rd(5, 8'h60, 8'hFF);
        rd(6, 8'h00, 8'hFF);
        repeat (4) begin
            d = 8'($random(seed)) & 8'h0F;
            wr(4, d);
            chk("dtr_n", !d[0], dtr_n);
            chk("rts_n", !d[1], rts_n);
            chk("op2_n", {!d[3], !d[3]}, {op2_n, oe_n});
        end
        wr(4, 8'h1B);
        chk("ser_tx", 1, ser_tx);
        rd(6, 8'hB0, 8'hF0);
        wr(4, 8'h14);
        rd(6, 8'h40, 8'hF0);
        wr(4, 8'h00);
        rd(6, 8'h00, 8'hF0);
        rd(6, 8'h00, 8'hFF);
        wr(1, 8'h08);
        peer.pins(4'b1110);
        chk("ms_int", 1, ms_int);
        rd(6, 8'h11, 8'hFF);
        peer.pins(4'b1010);
        rd(6, 8'h50, 8'hFF);
        peer.pins(4'b1110);
        rd(6, 8'h14, 8'hFF);
        wr(3, 8'h40);
        chk("ser_tx", 0, ser_tx);
        wr(3, 8'h00);
        chk("ser_tx", 1, ser_tx);
        d = 8'($random(seed));
        wr(0, d);
        chk("tx_valid", 1, tx_valid);
        rd(5, 8'h00, 8'hFF);
        for (int k = 0; k < 4; k++) begin
            wr(3, 8'h0B | 8'(k << 4));
            chk("tx_par", k[1] ? !k[0] : ^d ^ !k[0], tx_par);
        end
        @(posedge clock);
        take <= 1;
        busy <= 1;
        @(posedge clock);
        take <= 0;
        rd(5, 8'h20, 8'hFF);
        chk("tx_valid", 0, tx_valid);
        @(posedge clock) busy <= 0;
        rd(5, 8'h60, 8'hFF);
        wr(3, 8'h00);
        peer.send(8'hA5, 1);
        rd(5, 8'h61, 8'hFF);
        rd(0, 8'hA5, 8'hFF);
        peer.send(8'h11, 1);
        peer.send(8'h22, 1);
        rd(5, 8'h63, 8'hFF);
        rd(0, 8'h11, 8'hFF);
        rd(5, 8'h60, 8'hFF);
        peer.send(8'h33, 0);
        rd(5, 8'hE9, 8'hFF);
        rd(0, 8'h33, 8'hFF);
        wr(3, 8'h80);
        wr(0, 8'h34);
        wr(1, 8'h12);
        chk("divisor", 16'h1234, divisor);
        rd(0, 8'h34, 8'hFF);
        wr(3, 8'h00);
        wr(4, 8'hC0);
        rd(4, 8'h00, 8'hFF);
        wr(2, 8'h10);
        wr(4, 8'hC0);
        chk("ir_sel", 2'b10, {ir_sel, ir_tx});
        @(posedge clock) tx_bit <= 0;
        repeat (2) @(posedge clock);
        chk("ir_tx", 1, ir_tx);
        ticks = 0;
        repeat (8) @(posedge clock) ticks += baud;
        chk("ticks", 2, ticks);
        wr(4, 8'hE0);
        @(posedge clock) xhit <= 1;
        peer.send(8'h13, 1);
        chk("resume", 1, res_n);
        rd(5, 8'h60, 8'hFF);
        wr(2, 8'h90);
        peer.pins(4'b1111);
        chk("tx_halt", 1, tx_halt);
        @(posedge clock) {rs_en, busy} <= 2'b11;
        repeat (2) @(posedge clock);
        chk("rts_n", 0, rts_n);
        rd(7, 8'h00, 8'hFF);
        repeat (2) @(posedge clock);
        final_report;
    end
endmodule
